// ### design/cxp_defines.vh
// constants for the coprocessor transfer port: register map, fields, codes
// assumes a 32-bit apb slave with byte addresses and one word per register
`ifndef CXP_DEFINES_VH
`define CXP_DEFINES_VH

// register byte offsets
`define CXP_OFF_CTRL      12'h000
`define CXP_OFF_INSTR     12'h004
`define CXP_OFF_IADDR     12'h008
`define CXP_OFF_BASE      12'h00c
`define CXP_OFF_SRC       12'h010
`define CXP_OFF_FLAGS     12'h014
`define CXP_OFF_STATUS    12'h018
`define CXP_OFF_RESULT    12'h01c
`define CXP_OFF_CYCLES    12'h020

// control bits
`define CXP_CTRL_GO       0
`define CXP_CTRL_PRESENT  1
`define CXP_CTRL_RESET    32'h0000_0002

// status bits
`define CXP_ST_BUSY       0
`define CXP_ST_DONE       1
`define CXP_ST_SKIP       2
`define CXP_ST_UNDEF      3
`define CXP_ST_ABORT      4
`define CXP_ST_WB         5
`define CXP_ST_UNSUP      6

// instruction fields
`define CXP_F_COND        31:28
`define CXP_F_CLASS       27:25
`define CXP_F_PRE         24
`define CXP_F_UP          23
`define CXP_F_LEN         22
`define CXP_F_WB          21
`define CXP_F_DIR         20
`define CXP_F_BASE        19:16
`define CXP_F_CPREG       15:12
`define CXP_F_CPNUM       11:8
`define CXP_F_OFFS        7:0
`define CXP_F_FLAGS       31:28
`define CXP_CLASS_MEM     3'b110
`define CXP_CLASS_REG     4'b1110
`define CXP_PC_REG        4'hf

// pipeline adjustments and word step in bytes
`define CXP_PC_BASE_ADJ   32'h0000_0008
`define CXP_PC_SRC_ADJ    32'h0000_000c
`define CXP_WORD_STEP     32'h0000_0004

// cycle type codes on cyc_type
`define CXP_CYC_NONE      3'h0
`define CXP_CYC_SEQ       3'h1
`define CXP_CYC_NSEQ      3'h2
`define CXP_CYC_INT       3'h3
`define CXP_CYC_COP       3'h4

`endif

// ### design/cxp_port.v
// coprocessor transfer port: memory transfers and register moves between core and coprocessor
// assumes coprocessor and memory run on pclk; software loads operands over apb and starts it
//
// Function
// [RULE_01] execute only when condition passes
// [RULE_02] decode offset, cp number, cp register, base
// [RULE_03] bit 20 selects store or load
// [RULE_04] bit 21 writes modified address back
// [RULE_05] bit 23 adds or subtracts offset
// [RULE_06] bit 24 selects pre or post index
// [RULE_07] word offset shifted left two bits
// [RULE_08] post index writes back only if asked
// [RULE_09] first word at base, then plus four
// [RULE_10] core makes addresses, coprocessor sets count
// [RULE_11] coprocessor interprets length bit and register
// [RULE_12] coprocessor answers only its own number
// [RULE_13] low address bits driven unmodified
// [RULE_14] program counter base is address plus eight
// [RULE_15] abort traps but still writes base back
// [RULE_16] coprocessor stays restartable after abort
// [RULE_17] memory transfer timing n-1 S, 2 N, bI
// [RULE_18] move to program counter sets flags only
// [RULE_19] program counter source sends address plus twelve
// [RULE_20] register move timing per direction
// [RULE_21] direction bit one means coprocessor to core
// [RULE_22] coprocessor alone decodes its opcode fields
// [RULE_23] no coprocessor means undefined trap
// [RULE_24] stall while busy, start on acceptance
//
// Local design decisions: the register addresses and the APB slave port.
`timescale 1ns/1ps
`include "cxp_defines.vh"

module cxp_port (
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   output reg         cp_valid,
   output reg  [31:0] cp_instr,
   input  wire        cp_busy,
   input  wire        cp_accept,
   input  wire        cp_last,
   input  wire [31:0] cp_wdata,
   output reg         cp_word_taken,
   output reg  [31:0] cp_rdata,
   output reg         cp_rdata_valid,
   output reg         mem_req,
   output reg         mem_write,
   output reg  [31:0] mem_addr,
   output reg  [31:0] mem_wdata,
   input  wire [31:0] mem_rdata,
   input  wire        mem_ack,
   input  wire        mem_abort,
   output reg  [2:0]  cyc_type
);

   localparam [3:0] ST_IDLE  = 4'h0;
   localparam [3:0] ST_DEC   = 4'h1;
   localparam [3:0] ST_WAIT  = 4'h2;
   localparam [3:0] ST_EXTRA = 4'h3;
   localparam [3:0] ST_XFER  = 4'h4;
   localparam [3:0] ST_MEM   = 4'h5;
   localparam [3:0] ST_FIN   = 4'h6;

   reg  [3:0]  state_q;
   reg  [31:0] ctrl_q;
   reg  [31:0] instr_q;
   reg  [31:0] iaddr_q;
   reg  [31:0] base_q;
   reg  [31:0] src_q;
   reg  [3:0]  flags_q;
   reg  [6:0]  status_q;
   reg  [31:0] result_q;
   reg  [7:0]  cnt_s_q;
   reg  [7:0]  cnt_n_q;
   reg  [7:0]  cnt_i_q;
   reg  [7:0]  cnt_c_q;
   reg  [31:0] wb_addr_q;
   reg         wb_pend_q;

   // condition check against nzcv
   function cond_ok;
      input [3:0] c;
      input [3:0] f;
      reg         n;
      reg         z;
      reg         cy;
      reg         v;
      begin
         n  = f[3];
         z  = f[2];
         cy = f[1];
         v  = f[0];
         case (c)
            4'h0:    cond_ok = z;
            4'h1:    cond_ok = ~z;
            4'h2:    cond_ok = cy;
            4'h3:    cond_ok = ~cy;
            4'h4:    cond_ok = n;
            4'h5:    cond_ok = ~n;
            4'h6:    cond_ok = v;
            4'h7:    cond_ok = ~v;
            4'h8:    cond_ok = cy & ~z;
            4'h9:    cond_ok = ~cy | z;
            4'ha:    cond_ok = (n == v);
            4'hb:    cond_ok = (n != v);
            4'hc:    cond_ok = ~z & (n == v);
            4'hd:    cond_ok = z | (n != v);
            4'he:    cond_ok = 1'b1;
            default: cond_ok = 1'b0;
         endcase
      end
   endfunction

   // instruction decode
   wire        is_mem    = (instr_q[`CXP_F_CLASS] == `CXP_CLASS_MEM);
   wire        is_reg    = (instr_q[27:24] == `CXP_CLASS_REG) & instr_q[4];
   wire        dir_load  = instr_q[`CXP_F_DIR];                            // see [RULE_03] [RULE_21]
   wire [3:0]  base_sel  = instr_q[`CXP_F_BASE];                           // see [RULE_02]
   wire [3:0]  core_reg  = instr_q[`CXP_F_CPREG];
   wire        pass      = cond_ok(instr_q[`CXP_F_COND], flags_q);         // see [RULE_01]

   // address generation; the offset counts words, never bytes
   wire [31:0] offs_b    = {22'h0, instr_q[`CXP_F_OFFS], 2'b00};           // see [RULE_07]
   wire [31:0] base_val  = (base_sel == `CXP_PC_REG) ?
                           iaddr_q + `CXP_PC_BASE_ADJ : base_q;            // see [RULE_14]
   wire [31:0] mod_addr  = instr_q[`CXP_F_UP] ? base_val + offs_b :
                           base_val - offs_b;                              // see [RULE_05]
   wire [31:0] first_adr = instr_q[`CXP_F_PRE] ? mod_addr : base_val;      // see [RULE_06] [RULE_09]
   // write-back is never done to the program counter, even if asked
   wire        do_wb     = instr_q[`CXP_F_WB] & (base_sel != `CXP_PC_REG); // see [RULE_04] [RULE_08]
   wire [31:0] mcr_word  = (core_reg == `CXP_PC_REG) ?
                           iaddr_q + `CXP_PC_SRC_ADJ : src_q;              // see [RULE_19]

   wire        apb_setup = psel & ~penable;
   wire        apb_wr    = psel & penable & pwrite;
   wire        go        = apb_wr & (paddr == `CXP_OFF_CTRL) &
                           pwdata[`CXP_CTRL_GO] & (state_q == ST_IDLE);

   // apb read data and error prepared in setup so the access phase needs no wait
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
         pready  <= 1'b0;
      end else begin
         pready <= 1'b1;
         if (apb_setup) begin
            pslverr <= 1'b0;
            case (paddr)
               `CXP_OFF_CTRL:   prdata <= ctrl_q;
               `CXP_OFF_INSTR:  prdata <= instr_q;
               `CXP_OFF_IADDR:  prdata <= iaddr_q;
               `CXP_OFF_BASE:   prdata <= base_q;
               `CXP_OFF_SRC:    prdata <= src_q;
               `CXP_OFF_FLAGS:  prdata <= {flags_q, 28'h0};
               `CXP_OFF_STATUS: prdata <= {25'h0, status_q};
               `CXP_OFF_RESULT: prdata <= result_q;
               `CXP_OFF_CYCLES: prdata <= {cnt_c_q, cnt_i_q, cnt_n_q, cnt_s_q};
               default: begin
                  prdata  <= 32'h0000_0000;
                  pslverr <= 1'b1;
               end
            endcase
         end
      end
   end

   // software writable operands; writes are taken only while the sequencer is idle
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q  <= `CXP_CTRL_RESET;
         instr_q <= 32'h0000_0000;
         iaddr_q <= 32'h0000_0000;
         src_q   <= 32'h0000_0000;
      end else if (apb_wr && state_q == ST_IDLE) begin
         // operands freeze while an instruction runs
         case (paddr)
            `CXP_OFF_CTRL:  ctrl_q  <= {30'h0, pwdata[`CXP_CTRL_PRESENT], 1'b0};
            `CXP_OFF_INSTR: instr_q <= pwdata;
            `CXP_OFF_IADDR: iaddr_q <= pwdata;
            `CXP_OFF_SRC:   src_q   <= pwdata;
            default: ;
         endcase
      end
   end

   // main sequencer
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q        <= ST_IDLE;
         base_q         <= 32'h0000_0000;
         flags_q        <= 4'h0;
         status_q       <= 7'h00;
         result_q       <= 32'h0000_0000;
         cnt_s_q        <= 8'h00;
         cnt_n_q        <= 8'h00;
         cnt_i_q        <= 8'h00;
         cnt_c_q        <= 8'h00;
         wb_addr_q      <= 32'h0000_0000;
         wb_pend_q      <= 1'b0;
         cp_valid       <= 1'b0;
         cp_instr       <= 32'h0000_0000;
         cp_word_taken  <= 1'b0;
         cp_rdata       <= 32'h0000_0000;
         cp_rdata_valid <= 1'b0;
         mem_req        <= 1'b0;
         mem_write      <= 1'b0;
         mem_addr       <= 32'h0000_0000;
         mem_wdata      <= 32'h0000_0000;
         cyc_type       <= `CXP_CYC_NONE;
      end else begin
         cp_word_taken  <= 1'b0;
         cp_rdata_valid <= 1'b0;
         cyc_type       <= `CXP_CYC_NONE;
         if (state_q == ST_IDLE && apb_wr) begin
            if (paddr == `CXP_OFF_BASE)
               base_q <= pwdata;
            if (paddr == `CXP_OFF_FLAGS)
               flags_q <= pwdata[`CXP_F_FLAGS];
         end
         case (state_q)
            ST_IDLE: begin
               if (go) begin
                  status_q <= 7'h01;
                  cnt_s_q  <= 8'h00;
                  cnt_n_q  <= 8'h00;
                  cnt_i_q  <= 8'h00;
                  cnt_c_q  <= 8'h00;
                  if (!pass) begin
                     status_q <= 7'h06;                                     // see [RULE_01]
                  end else if (!ctrl_q[`CXP_CTRL_PRESENT] && (is_mem || is_reg)) begin
                     status_q <= 7'h0a;                                     // see [RULE_23]
                  end else if (!is_mem && !is_reg) begin
                     status_q <= 7'h42;
                  end else begin
                     // the whole word goes out; fields above are the coprocessor's
                     cp_valid <= 1'b1;                                      // see [RULE_22] [RULE_12]
                     cp_instr <= instr_q;                                   // see [RULE_11]
                     state_q  <= is_mem ? ST_WAIT : ST_DEC;
                  end
               end
            end
            ST_DEC: begin
               // opening sequential cycle of a register move
               cyc_type <= `CXP_CYC_SEQ;
               cnt_s_q  <= cnt_s_q + 8'h01;                                 // see [RULE_20]
               state_q  <= ST_WAIT;
            end
            ST_WAIT: begin
               if (cp_accept) begin
                  cp_valid <= 1'b0;                                         // see [RULE_24]
                  if (is_mem) begin
                     mem_req   <= 1'b1;                                     // see [RULE_10]
                     mem_write <= ~dir_load;                                // see [RULE_03]
                     mem_addr  <= first_adr;                                // see [RULE_13]
                     mem_wdata <= cp_wdata;
                     cp_word_taken <= ~dir_load;
                     wb_addr_q <= mod_addr;
                     wb_pend_q <= do_wb;
                     cyc_type  <= `CXP_CYC_NSEQ;
                     cnt_n_q   <= cnt_n_q + 8'h01;                          // see [RULE_17]
                     state_q   <= ST_MEM;
                  end else if (dir_load) begin
                     cyc_type <= `CXP_CYC_INT;
                     cnt_i_q  <= cnt_i_q + 8'h01;                           // see [RULE_20]
                     state_q  <= ST_EXTRA;
                  end else begin
                     cp_rdata       <= mcr_word;                            // see [RULE_19]
                     cp_rdata_valid <= 1'b1;
                     cyc_type       <= `CXP_CYC_COP;
                     cnt_c_q        <= cnt_c_q + 8'h01;                     // see [RULE_20]
                     state_q        <= ST_FIN;
                  end
               end else if (cp_busy) begin
                  // busy-wait costs one internal cycle each
                  cyc_type <= `CXP_CYC_INT;
                  cnt_i_q  <= cnt_i_q + 8'h01;                              // see [RULE_24] [RULE_17]
               end else begin
                  // nobody claimed it: undefined trap
                  cp_valid <= 1'b0;
                  status_q <= 7'h0a;                                        // see [RULE_23]
                  state_q  <= ST_IDLE;
               end
            end
            ST_EXTRA: begin
               // coprocessor presents its word in the transfer cycle
               cyc_type <= `CXP_CYC_COP;
               cnt_c_q  <= cnt_c_q + 8'h01;                                 // see [RULE_20]
               state_q  <= ST_XFER;
            end
            ST_XFER: begin
               if (core_reg == `CXP_PC_REG)
                  flags_q <= cp_wdata[`CXP_F_FLAGS];                        // see [RULE_18]
               else
                  result_q <= cp_wdata;
               status_q <= 7'h02;
               state_q  <= ST_IDLE;
            end
            ST_MEM: begin
               if (mem_ack) begin
                  if (dir_load && !mem_abort) begin
                     cp_rdata       <= mem_rdata;
                     cp_rdata_valid <= 1'b1;
                  end
                  if (mem_abort || cp_last) begin
                     // abort ends the transfer; write-back still happens below
                     mem_req <= 1'b0;
                     status_q[`CXP_ST_ABORT] <= mem_abort;                  // see [RULE_15] [RULE_16]
                     cyc_type <= `CXP_CYC_NSEQ;
                     cnt_n_q  <= cnt_n_q + 8'h01;                           // see [RULE_17]
                     state_q  <= ST_FIN;
                  end else begin
                     mem_addr  <= mem_addr + `CXP_WORD_STEP;                // see [RULE_09]
                     mem_wdata <= cp_wdata;
                     cp_word_taken <= ~dir_load;
                     cyc_type  <= `CXP_CYC_SEQ;
                     cnt_s_q   <= cnt_s_q + 8'h01;                          // see [RULE_17]
                  end
               end
            end
            ST_FIN: begin
               if (wb_pend_q) begin
                  base_q <= wb_addr_q;                                      // see [RULE_04] [RULE_15]
                  status_q[`CXP_ST_WB] <= 1'b1;
               end
               wb_pend_q <= 1'b0;
               if (!is_mem)
                  status_q[`CXP_ST_ABORT] <= 1'b0;
               status_q[`CXP_ST_BUSY] <= 1'b0;
               status_q[`CXP_ST_DONE] <= 1'b1;
               state_q <= ST_IDLE;
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

endmodule // cxp_port

// ### verification/cxp_port_monitor.sv
// pin-level checker for the coprocessor transfer port
// assumes it is bound onto cxp_port and that everything runs on pclk
`timescale 1ns/1ps
`include "cxp_defines.vh"
module cxp_port_monitor (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic [11:0] paddr,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        cp_valid,
   input wire logic [31:0] cp_instr,
   input wire logic        cp_busy,
   input wire logic        cp_accept,
   input wire logic        cp_last,
   input wire logic [31:0] cp_wdata,
   input wire logic        cp_word_taken,
   input wire logic [31:0] cp_rdata,
   input wire logic        cp_rdata_valid,
   input wire logic        mem_req,
   input wire logic        mem_write,
   input wire logic [31:0] mem_addr,
   input wire logic [31:0] mem_wdata,
   input wire logic [31:0] mem_rdata,
   input wire logic        mem_ack,
   input wire logic        mem_abort,
   input wire logic [2:0]  cyc_type
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // the steps of a memory transfer, shared by the properties below
   sequence word_ack; mem_req && mem_ack && !mem_abort && !cp_last; endsequence
   sequence end_ack; mem_req && mem_ack && (mem_abort || cp_last); endsequence
   sequence start_mem; cp_valid && cp_accept && cp_instr[27:25] == 3'b110; endsequence

   // zero-wait slave: the first edge after release is still skipped
   pready_up_a: assert property ($past(presetn) |-> pready)
      else $error("pready low outside reset");
   unmapped_err_a: assert property (psel && penable && paddr > `CXP_OFF_CYCLES |-> pslverr)
      else $error("no slave error on unmapped address");
   addr_step_a: assert property (word_ack |=> mem_req && mem_addr == $past(mem_addr) + 32'h4)
      else $error("next word address not four above");
   seq_cycle_a: assert property (word_ack |=> cyc_type == `CXP_CYC_SEQ)
      else $error("following word not a sequential cycle");
   end_release_a: assert property (end_ack |=> !mem_req)
      else $error("memory request kept after last word");
   start_dir_a: assert property (start_mem |=> mem_req && !cp_valid
      && cyc_type == `CXP_CYC_NSEQ && mem_write == !$past(cp_instr[20]))
      else $error("wrong start of memory transfer");
   hold_req_a: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
      else $error("request changed before acknowledge");
   stall_bound_a: assert property ($rose(cp_valid) |-> ##[1:40] !cp_valid)
      else $error("offer to coprocessor never resolved");
   load_pass_a: assert property (mem_req && mem_ack && !mem_abort && !mem_write
      |=> cp_rdata_valid && cp_rdata == $past(mem_rdata))
      else $error("load word not handed to coprocessor");
   store_feed_a: assert property (word_ack ##0 mem_write
      |=> cp_word_taken && mem_wdata == $past(cp_wdata))
      else $error("store word not taken from coprocessor");
   abort_quiet_a: assert property (mem_req && mem_ack && mem_abort |=> !cp_rdata_valid)
      else $error("aborted word passed on");
endmodule // cxp_port_monitor
bind cxp_port cxp_port_monitor i_cxp_port_monitor (.*);

// ### verification/cxp_cop_model.sv
// coprocessor and memory responder standing at the far side of the port
// assumes the bench sets busy length, word count, abort word and memory pace
`timescale 1ns/1ps
module cxp_cop_model #(parameter logic [3:0] OWN_NUM = 4'h1) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        cp_valid,
   input  wire logic [31:0] cp_instr,
   input  wire logic        mem_req,
   input  wire logic [31:0] mem_addr,
   input  wire logic [3:0]  busy_n,
   input  wire logic [7:0]  words,
   input  wire logic [7:0]  abort_at,
   input  wire logic        slow,
   output logic             cp_busy,
   output logic             cp_accept,
   output logic             cp_last,
   output logic [31:0]      cp_wdata,
   output logic [31:0]      mem_rdata,
   output logic             mem_ack,
   output logic             mem_abort
);
   logic [3:0] bcnt_q;
   logic [7:0] wcnt_q;
   logic       tog_q;
   logic       sel;
   // claim only our own number; the other fields are read by nobody else
   assign sel = cp_valid && cp_instr[11:8] == OWN_NUM;
   // busy-wait for busy_n cycles, then take the instruction
   assign cp_busy   = sel && bcnt_q < busy_n;
   assign cp_accept = sel && bcnt_q >= busy_n;
   // the bench picks the length that the length bit would select here
   assign cp_last   = wcnt_q == words - 8'h01;
   assign cp_wdata  = 32'h9abc_0000 | {24'h0, wcnt_q};
   // slow pace answers every second cycle; data is only meaningful with ack
   assign mem_ack   = mem_req && (!slow || tog_q);
   assign mem_abort = mem_ack && wcnt_q + 8'h01 == abort_at;
   assign mem_rdata = mem_ack ? ~mem_addr : mem_addr;
   // counts clear whenever idle, so a retried instruction starts clean
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bcnt_q <= 4'h0;
         wcnt_q <= 8'h0;
         tog_q  <= 1'b0;
      end else begin
         tog_q  <= !tog_q;
         bcnt_q <= !cp_valid ? 4'h0 : bcnt_q + {3'h0, cp_busy};
         wcnt_q <= (!cp_valid && !mem_req) ? 8'h0 : wcnt_q + {7'h0, mem_ack};
      end
   end
endmodule // cxp_cop_model

// ### verification/testbench.sv
// self-checking bench for the coprocessor transfer port
// assumes cxp_port, the coprocessor model and the pin checker compile beside it
`timescale 1ns/1ps
`include "cxp_defines.vh"
module testbench;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, slow, req_q, pres;
   logic        cp_valid, cp_busy, cp_accept, cp_last, cp_word_taken, cp_rdata_valid;
   logic        mem_req, mem_write, mem_ack, mem_abort;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, cp_instr, cp_wdata, cp_rdata, mem_addr, mem_wdata, mem_rdata;
   logic [31:0] first_addr, last_rd;
   logic [2:0]  cyc_type;
   logic [3:0]  busy_n;
   logic [7:0]  words, abort_at;
   int          err_total = 0;
   int          checks_done = 0;

   cxp_port i_cxp_port (.*);
   cxp_cop_model i_cxp_cop_model (.*);

   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   // remember the first address of each transfer and the last word sent out
   always @(posedge pclk) begin
      req_q <= mem_req;
      if (mem_req && !req_q) first_addr <= mem_addr;
      if (cp_rdata_valid) last_rd <= cp_rdata;
   end

   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // one apb transfer; entered just after a rising edge, leaves one idle cycle
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      apb(1'b1, a, d, r);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      logic [31:0] r;
      apb(1'b0, a, 32'h0, r);
      chk(r, e);
   endtask
   // load operands, start, wait until idle and compare the status word
   task automatic run(input logic [31:0] ins, base, ia, input logic [3:0] b,
                      input logic [7:0] nw, ab, input logic [31:0] st);
      logic [31:0] r;
      busy_n <= b;
      words <= nw;
      abort_at <= ab;
      wr(`CXP_OFF_INSTR, ins);
      wr(`CXP_OFF_BASE, base);
      wr(`CXP_OFF_IADDR, ia);
      // present bit goes in first: the start write is judged on the old control word
      wr(`CXP_OFF_CTRL, {30'h0, pres, 1'b0});
      wr(`CXP_OFF_CTRL, {30'h0, pres, 1'b1});
      repeat (100) begin
         apb(1'b0, `CXP_OFF_STATUS, 32'h0, r);
         if (r[0] !== 1'b1) break;
      end
      chk(r, st);
   endtask

   task t_reset;
      rd(`CXP_OFF_CTRL, 32'h2);
      rd(`CXP_OFF_STATUS, 32'h0);
      rd(12'h040, 32'h0);
   endtask
   task t_store_pre;
      run(32'heda3_2103, 32'h1000, 32'h0, 4'h2, 8'h3, 8'h0, 32'h22);
      chk(first_addr, 32'h100c);
      rd(`CXP_OFF_BASE, 32'h100c);
      rd(`CXP_OFF_CYCLES, 32'h0002_0202);
   endtask
   task t_post;
      slow <= 1'b1;
      run(32'hec33_2104, 32'h4000, 32'h0, 4'h0, 8'h2, 8'h0, 32'h22);
      chk(first_addr, 32'h4000);
      rd(`CXP_OFF_BASE, 32'h3ff0);
      run(32'hec13_2104, 32'h4000, 32'h0, 4'h0, 8'h1, 8'h0, 32'h02);
      rd(`CXP_OFF_BASE, 32'h4000);
      slow <= 1'b0;
   endtask
   task t_edges;
      run(32'hed13_21ff, 32'h1000, 32'h0, 4'h0, 8'h1, 8'h0, 32'h02);
      chk(first_addr, 32'h0c04);
      run(32'hed83_2100, 32'h1002, 32'h0, 4'h0, 8'h1, 8'h0, 32'h02);
      chk(first_addr, 32'h1002);
      run(32'hec3f_2104, 32'h4000, 32'h200, 4'h0, 8'h1, 8'h0, 32'h02);
      chk(first_addr, 32'h208);
      rd(`CXP_OFF_BASE, 32'h4000);
      rd(`CXP_OFF_CYCLES, 32'h0000_0200);
   endtask
   task t_abort;
      run(32'hedb3_2101, 32'h1000, 32'h0, 4'h0, 8'h3, 8'h2, 32'h32);
      chk(first_addr, 32'h1004);
      chk(last_rd, 32'hffff_effb);
      rd(`CXP_OFF_BASE, 32'h1004);
   endtask
   task t_cond;
      wr(`CXP_OFF_FLAGS, 32'h0);
      run(32'h0da3_2101, 32'h1000, 32'h0, 4'h0, 8'h1, 8'h0, 32'h06);
      rd(`CXP_OFF_BASE, 32'h1000);
      wr(`CXP_OFF_FLAGS, 32'h4000_0000);
      run(32'h0da3_2101, 32'h1000, 32'h0, 4'h0, 8'h1, 8'h0, 32'h22);
      run(32'h1da3_2101, 32'h1000, 32'h0, 4'h0, 8'h1, 8'h0, 32'h06);
   endtask
   task t_refuse;
      run(32'heda3_2501, 32'h1000, 32'h0, 4'h0, 8'h1, 8'h0, 32'h0a);
      pres = 1'b0;
      run(32'heda3_2101, 32'h1000, 32'h0, 4'h0, 8'h1, 8'h0, 32'h0a);
      pres = 1'b1;
      run(32'he000_0000, 32'h1000, 32'h0, 4'h0, 8'h1, 8'h0, 32'h42);
   endtask
   task t_moves;
      // the first busy cycle overlaps the opening sequential cycle, so b of two costs one busy-wait cycle here
      run(32'hee10_f110, 32'h0, 32'h0, 4'h2, 8'h1, 8'h0, 32'h02);
      rd(`CXP_OFF_FLAGS, 32'h9000_0000);
      rd(`CXP_OFF_CYCLES, 32'h0102_0001);
      run(32'hee10_3110, 32'h0, 32'h0, 4'h0, 8'h1, 8'h0, 32'h02);
      rd(`CXP_OFF_RESULT, 32'h9abc_0000);
      run(32'hee00_f110, 32'h0, 32'h300, 4'h0, 8'h1, 8'h0, 32'h02);
      chk(last_rd, 32'h30c);
      rd(`CXP_OFF_CYCLES, 32'h0100_0001);
      wr(`CXP_OFF_SRC, 32'h1234_5678);
      run(32'hee00_2110, 32'h0, 32'h0, 4'h0, 8'h1, 8'h0, 32'h02);
      chk(last_rd, 32'h1234_5678);
   endtask

   task wrap_up;
      $display("comparisons %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // main sequence: reset for 16 cycles, then every scenario in turn
   initial begin
      {psel, penable, pwrite, slow, presetn} = 5'h0;
      {paddr, pwdata, busy_n, words, abort_at} = 0;
      pres = 1'b1;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset;
      t_store_pre;
      t_post;
      t_edges;
      t_abort;
      t_cond;
      t_refuse;
      t_moves;
      wrap_up;
   end
   // a hang is cut short long after the scenarios should have ended
   initial begin
      repeat (20000) @(posedge pclk);
      err_total++;
      wrap_up;
   end
endmodule // testbench
